// ---- bpaio_pkg.sv ----
// Package: constants and carriers for the bidirectional port A block
//-----------------------------------------------------------------------
//-----------------------------------------------------------------------
package bpaio_pkg;

   //--------------------------------------------------------------------
   // Register map
   //--------------------------------------------------------------------
   localparam int ADDR_W = 5;                          // Byte address
   localparam logic [4:0] OFS_PIN_LEVEL = 5'h00;       // Pin levels
   localparam logic [4:0] OFS_OUT_LATCH = 5'h04;       // Output latch
   localparam logic [4:0] OFS_PIN_DIR = 5'h08;         // Direction
   localparam logic [4:0] OFS_ANA_SEL = 5'h0C;         // Analog select
   localparam logic [4:0] OFS_PIN_SET = 5'h10;         // Modify: set
   localparam logic [4:0] OFS_PIN_CLR = 5'h14;         // Modify: clear

   //--------------------------------------------------------------------
   // Field layouts and reset values
   //--------------------------------------------------------------------
   localparam logic [7:0] DIR_RESET = 8'hFF;           // All inputs
   localparam logic [7:0] DIR_FORCED = 8'h08;          // Pin three
   localparam logic [7:0] LAT_RESET = 8'h00;           // Latch clear
   localparam logic [7:0] ANA_MASK = 8'h2F;            // Bits 5, 3..0
   localparam logic [7:0] ANA_RESET = 8'h2F;           // Analog mode
   localparam logic [7:0] BYTE_ZERO = 8'h00;           // Filler
   localparam logic [23:0] PAD_ZERO = 24'h00_0000;     // Upper lanes
   localparam logic [1:0] RESP_OKAY = 2'h0;            // AXI okay
   localparam logic [1:0] RESP_SLVERR = 2'h2;          // AXI error

   //--------------------------------------------------------------------
   // Bus carriers
   //--------------------------------------------------------------------
   typedef struct packed {
      logic awvalid;             // Write address valid
      logic [4:0] awaddr;        // Write address
      logic wvalid;              // Write data valid
      logic [31:0] wdata;        // Write data
      logic [3:0] wstrb;         // Byte enables
      logic bready;              // Response ready
      logic arvalid;             // Read address valid
      logic [4:0] araddr;        // Read address
      logic rready;              // Read data ready
   } bpaio_axi_req_t;

   typedef struct packed {
      logic awready;             // Write address ready
      logic wready;              // Write data ready
      logic bvalid;              // Response valid
      logic [1:0] bresp;         // Response code
      logic arready;             // Read address ready
      logic rvalid;              // Read data valid
      logic [31:0] rdata;        // Read data
      logic [1:0] rresp;         // Read response
   } bpaio_axi_rsp_t;

   // Output functions competing for one pin, high then low priority
   typedef struct packed {
      logic [7:0] hiEn;          // High-priority function enables
      logic [7:0] hiData;        // High-priority function data
      logic [7:0] loEn;          // Low-priority function enables
      logic [7:0] loData;        // Low-priority function data
   } bpaio_periph_t;

endpackage : bpaio_pkg

// ---- bpaio_port.sv ----
// Module: eight-bit port A with AXI4-Lite register access
`timescale 1ns/1ns

module bpaio_port
(
   input wire logic clock,                      // 25 MHz system clock
   input wire logic rstn,                       // Async reset, low
   input wire bpaio_pkg::bpaio_axi_req_t axiReq, // Bus requests
   output bpaio_pkg::bpaio_axi_rsp_t axiRsp,    // Bus answers
   input wire bpaio_pkg::bpaio_periph_t periph, // Peripheral outputs
   input wire logic [7:0] pinIn,                // Pin levels
   output logic [7:0] pinOut,                   // Pin drive values
   output logic [7:0] pinOe,                    // Pin drive enables
   output logic [7:0] digitalIn                 // Digital input buffer
);

   //--------------------------------------------------------------------
   // State
   //--------------------------------------------------------------------
   typedef struct packed {
      logic awHeld;              // Write address captured
      logic [4:0] awAddr;        // Captured write address
      logic wHeld;               // Write data captured
      logic [7:0] wData;         // Captured low byte
      logic wLane0;              // Low byte enabled
      logic awready;             // Address ready
      logic wready;              // Data ready
      logic bvalid;              // Response pending
      logic [1:0] bresp;         // Response code
      logic arready;             // Read address ready
      logic rvalid;              // Read data pending
      logic [7:0] rdata;         // Read byte
      logic [1:0] rresp;         // Read code
      logic [7:0] dir;           // Direction bits
      logic [7:0] lat;           // Output latch
      logic [7:0] ana;           // Analog select
      logic [7:0] sync1;         // First synchroniser stage
      logic [7:0] sync2;         // Second synchroniser stage
      logic [7:0] pinOut;        // Registered drive values
      logic [7:0] pinOe;         // Registered drive enables
      logic [7:0] digIn;         // Registered digital input
   } bpaio_state_t;

   bpaio_state_t st_ff;          // Current state
   bpaio_state_t nxt_st;         // Next state

   logic [7:0] pinRead;          // Digital view of the pins
   logic [7:0] outSel;           // Value chosen for each pin

   //--------------------------------------------------------------------
   // Address decoding
   //--------------------------------------------------------------------
   // Hit test shared by the read and write decoders
   function automatic logic addrHit
   (
      input logic [4:0] addr,
      input logic [4:0] ofs
   );
      addrHit = (addr == ofs);
   endfunction : addrHit

   // Mapped check shared by both decoders
   function automatic logic addrMapped
   (
      input logic [4:0] addr
   );
      addrMapped = addrHit(addr, bpaio_pkg::OFS_PIN_LEVEL)
         | addrHit(addr, bpaio_pkg::OFS_OUT_LATCH)
         | addrHit(addr, bpaio_pkg::OFS_PIN_DIR)
         | addrHit(addr, bpaio_pkg::OFS_ANA_SEL)
         | addrHit(addr, bpaio_pkg::OFS_PIN_SET)
         | addrHit(addr, bpaio_pkg::OFS_PIN_CLR);
   endfunction : addrMapped

   //--------------------------------------------------------------------
   // Pin paths
   //--------------------------------------------------------------------
   // Analog pins lose their input buffer and read zero
   assign pinRead = st_ff.sync2 & ~st_ff.ana;

   // Per-pin output priority: high function, low function, then latch
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : gPinMux
         always_comb
         begin
            if (periph.hiEn[gi])
            begin
               // Highest priority function owns the pin
               outSel[gi] = periph.hiData[gi];
            end
            else if (periph.loEn[gi])
            begin
               // Next function down
               outSel[gi] = periph.loData[gi];
            end
            else
            begin
               // General-purpose latch last
               outSel[gi] = st_ff.lat[gi];
            end
         end
      end
   endgenerate

   //--------------------------------------------------------------------
   // Next-state logic
   //--------------------------------------------------------------------
   // Bus slave, register updates and pin drive in one pass
   always_comb
   begin
      logic doWrite;
      logic doRead;
      logic [7:0] wByte;
      doWrite = 1'b0;
      doRead = 1'b0;
      wByte = bpaio_pkg::BYTE_ZERO;
      nxt_st = st_ff;

      // Two-stage synchroniser on the pins
      nxt_st.sync1 = pinIn;
      nxt_st.sync2 = st_ff.sync1;

      // Capture write address when offered
      if (st_ff.awready && axiReq.awvalid)
      begin
         nxt_st.awHeld = 1'b1;
         nxt_st.awAddr = axiReq.awaddr;
      end

      // Capture write data when offered, in either order
      if (st_ff.wready && axiReq.wvalid)
      begin
         nxt_st.wHeld = 1'b1;
         nxt_st.wData = axiReq.wdata[7:0];
         nxt_st.wLane0 = axiReq.wstrb[0];
      end

      // Both halves held and no answer pending: perform the write
      if (st_ff.awHeld && st_ff.wHeld && !st_ff.bvalid)
      begin
         doWrite = 1'b1;
         nxt_st.awHeld = 1'b0;
         nxt_st.wHeld = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = addrMapped(st_ff.awAddr) ?
            bpaio_pkg::RESP_OKAY : bpaio_pkg::RESP_SLVERR;
      end

      // Response retired by the master
      if (st_ff.bvalid && axiReq.bready)
      begin
         nxt_st.bvalid = 1'b0;
      end

      // Ready only while that half is free and nothing is answered
      nxt_st.awready = !nxt_st.awHeld && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.wHeld && !nxt_st.bvalid;

      // Register writes; only the low byte lane carries data
      wByte = st_ff.wData;
      if (doWrite && st_ff.wLane0)
      begin
         if (addrHit(st_ff.awAddr, bpaio_pkg::OFS_PIN_LEVEL)
            || addrHit(st_ff.awAddr, bpaio_pkg::OFS_OUT_LATCH))
         begin
            // Both addresses land in the latch alike
            nxt_st.lat = wByte;
         end
         else if (addrHit(st_ff.awAddr, bpaio_pkg::OFS_PIN_SET))
         begin
            // Pins read, bits set, result into the latch; an
            // analog pin reads zero here and loses its latch bit
            nxt_st.lat = pinRead | wByte;
         end
         else if (addrHit(st_ff.awAddr, bpaio_pkg::OFS_PIN_CLR))
         begin
            // Pins read, bits cleared, result into the latch
            nxt_st.lat = pinRead & ~wByte;
         end
         else if (addrHit(st_ff.awAddr, bpaio_pkg::OFS_PIN_DIR))
         begin
            // Pin three stays an input whatever is written
            nxt_st.dir = wByte | bpaio_pkg::DIR_FORCED;
         end
         else if (addrHit(st_ff.awAddr, bpaio_pkg::OFS_ANA_SEL))
         begin
            // Unimplemented select bits stay zero
            nxt_st.ana = wByte & bpaio_pkg::ANA_MASK;
         end
      end

      // Read channel: one read at a time
      if (st_ff.arready && axiReq.arvalid)
      begin
         doRead = 1'b1;
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = addrMapped(axiReq.araddr) ?
            bpaio_pkg::RESP_OKAY : bpaio_pkg::RESP_SLVERR;
         if (addrHit(axiReq.araddr, bpaio_pkg::OFS_PIN_LEVEL))
         begin
            // Actual pin levels, analog pins as zero
            nxt_st.rdata = pinRead;
         end
         else if (addrHit(axiReq.araddr, bpaio_pkg::OFS_OUT_LATCH))
         begin
            // Stored latch contents
            nxt_st.rdata = st_ff.lat;
         end
         else if (addrHit(axiReq.araddr, bpaio_pkg::OFS_PIN_DIR))
         begin
            nxt_st.rdata = st_ff.dir;
         end
         else if (addrHit(axiReq.araddr, bpaio_pkg::OFS_ANA_SEL))
         begin
            nxt_st.rdata = st_ff.ana;
         end
         else
         begin
            // Modify registers and holes read as zero
            nxt_st.rdata = bpaio_pkg::BYTE_ZERO;
         end
      end
      else if (st_ff.rvalid && axiReq.rready)
      begin
         nxt_st.rvalid = 1'b0;
      end
      nxt_st.arready = !nxt_st.rvalid && !doRead;

      // Drivers follow direction only; analog select is ignored so an
      // analog pin with direction clear still drives
      nxt_st.pinOe = ~nxt_st.dir;
      nxt_st.pinOut = outSel;

      // Digital input offered to peripherals, buffer off when analog;
      // fed from the second stage only, so no flop but the second
      // synchroniser stage ever samples the first
      nxt_st.digIn = st_ff.sync2 & ~nxt_st.ana;
   end

   //--------------------------------------------------------------------
   // State register
   //--------------------------------------------------------------------
   // Reset puts every pin in input mode and pins 5 and 3..0 in analog mode
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         st_ff <= '0;
         st_ff.dir <= bpaio_pkg::DIR_RESET;
         st_ff.lat <= bpaio_pkg::LAT_RESET;
         st_ff.ana <= bpaio_pkg::ANA_RESET;
         st_ff.digIn <= bpaio_pkg::BYTE_ZERO;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   //--------------------------------------------------------------------
   // Outputs, all from flip-flops
   //--------------------------------------------------------------------
   assign axiRsp.awready = st_ff.awready;
   assign axiRsp.wready = st_ff.wready;
   assign axiRsp.bvalid = st_ff.bvalid;
   assign axiRsp.bresp = st_ff.bresp;
   assign axiRsp.arready = st_ff.arready;
   assign axiRsp.rvalid = st_ff.rvalid;
   assign axiRsp.rdata = {bpaio_pkg::PAD_ZERO, st_ff.rdata};
   assign axiRsp.rresp = st_ff.rresp;
   assign pinOut = st_ff.pinOut;
   assign pinOe = st_ff.pinOe;
   assign digitalIn = st_ff.digIn;

endmodule : bpaio_port

// ---- bpaio_pin_model.sv ----
// Board model: levels seen on the eight port A pins
`timescale 1ns/1ns

module bpaio_pin_model
(
   input wire logic [7:0] pinOe,    // Port drive enables
   input wire logic [7:0] pinOut,   // Port drive values
   input wire logic [7:0] extLevel, // Board drive on free pins
   output logic [7:0] pinIn         // Resolved pin levels
);
   //------------------------------------------
   // Pin resolution
   //------------------------------------------
   // Board drives only undriven pins, so a port contention never shows
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : bpaio_pin_model

// ---- bpaio_port_sva.sv ----
// Checker: bus and pin assertions for port A
`timescale 1ns/1ns

module bpaio_port_sva
(
   input wire logic clock,                         // System clock
   input wire logic rstn,                          // Reset, low
   input wire bpaio_pkg::bpaio_axi_req_t axiReq,   // Bus requests
   input wire bpaio_pkg::bpaio_axi_rsp_t axiRsp,   // Bus answers
   input wire bpaio_pkg::bpaio_periph_t periph,    // Peripheral outputs
   input wire logic [7:0] pinIn,                   // Pin levels
   input wire logic [7:0] pinOut,                  // Drive values
   input wire logic [7:0] pinOe,                   // Drive enables
   input wire logic [7:0] digitalIn                // Input buffer
);
   logic wrSeen_ff; // A write was taken since reset
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Analog reset state is only guaranteed until the first write
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         wrSeen_ff <= 1'b0;
      else if (axiReq.awvalid && axiRsp.awready)
         wrSeen_ff <= 1'b1;
   end
   //------------------------------------------
   // Pins
   //------------------------------------------
   a_pin3_never_driven: assert property (pinOe[3] == 1'b0)
      else $error("pin three driven");
   a_analog_reset_zero: assert property (!wrSeen_ff |->
      (digitalIn & bpaio_pkg::ANA_MASK) == 8'h00)
      else $error("analog pin read digital after reset");
   a_input_sync_lands: assert property ($rose(pinIn[7]) ##1
      pinIn[7] [*4] |-> digitalIn[7])
      else $error("digital input not following pin");
   a_high_prio_owns: assert property (1'b1 |=>
      (pinOut & $past(periph.hiEn)) ==
      ($past(periph.hiData) & $past(periph.hiEn)))
      else $error("high priority function lost pin");
   //------------------------------------------
   // Bus
   //------------------------------------------
   // Both halves taken at one edge: update and response one edge later,
   // so bvalid is first sampled high two edges after the take
   a_write_resp_next: assert property (axiReq.awvalid &&
      axiRsp.awready && axiReq.wvalid && axiRsp.wready |-> ##2
      axiRsp.bvalid)
      else $error("write response late");
   a_read_data_next: assert property (axiReq.arvalid &&
      axiRsp.arready |=> axiRsp.rvalid)
      else $error("read data late");
   a_write_refused: assert property (axiRsp.bvalid |->
      !axiRsp.awready && !axiRsp.wready)
      else $error("write taken during response");
   a_read_refused: assert property (axiRsp.rvalid |->
      !axiRsp.arready)
      else $error("read taken during data");
   a_rdata_upper_zero: assert property (axiRsp.rvalid |->
      axiRsp.rdata[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
endmodule : bpaio_port_sva

bind bpaio_port bpaio_port_sva chk (.clock(clock), .rstn(rstn),
   .axiReq(axiReq), .axiRsp(axiRsp), .periph(periph), .pinIn(pinIn),
   .pinOut(pinOut), .pinOe(pinOe), .digitalIn(digitalIn));

// ---- bpaio_port_tb.sv ----
// Testbench: port A register and pin scenarios
`timescale 1ns/1ns

module bpaio_port_tb;
   logic clock;                       // System clock
   logic rstn;                        // Reset, low
   bpaio_pkg::bpaio_axi_req_t req;    // Bus requests
   bpaio_pkg::bpaio_axi_rsp_t rsp;    // Bus answers
   bpaio_pkg::bpaio_periph_t periph;  // Peripheral drive
   logic [7:0] pinIn;                 // Resolved pins
   logic [7:0] pinOut;                // Port drive values
   logic [7:0] pinOe;                 // Port drive enables
   logic [7:0] digitalIn;             // Input buffer
   logic [7:0] extLevel;              // Board level on free pins
   logic [1:0] resp;                  // Last response code
   logic [31:0] rd;                   // Last read data
   logic [3:0] wrStrb;                // Byte enables for next write
   int errTotal = 0;                  // Mismatches
   int numChecks = 0;                 // Comparisons
   int cycles = 0;                    // Watchdog count

   bpaio_port dut (.clock(clock), .rstn(rstn), .axiReq(req), .axiRsp(rsp),
      .periph(periph), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .digitalIn(digitalIn));
   bpaio_pin_model board (.pinOe(pinOe), .pinOut(pinOut),
      .extLevel(extLevel), .pinIn(pinIn));
   //------------------------------------------
   // Clock and watchdog
   //------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Whole run needs well under two hundred cycles; a hang ends here
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         errTotal = errTotal + 1;
         finish_test();
      end
   end
   //------------------------------------------
   // Bus tasks
   //------------------------------------------
   // Address and data offered together, each released when taken
   task automatic axi_write(input logic [4:0] a, input logic [7:0] d);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= {24'h00_0000, d};
      req.wstrb <= wrStrb;
      req.bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (req.awvalid && rsp.awready === 1'b1)
         begin
            awDone = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (req.wvalid && rsp.wready === 1'b1)
         begin
            wDone = 1'b1;
            req.wvalid <= 1'b0;
         end
      end while (!(awDone && wDone));
      do @(posedge clock); while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
      req.bready <= 1'b0;
      // Idle edge keeps strobes from being set twice in one step
      @(posedge clock);
   endtask : axi_write

   task automatic axi_read(input logic [4:0] a);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do @(posedge clock); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge clock); while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
      @(posedge clock);
   endtask : axi_read
   //------------------------------------------
   // Compare tasks
   //------------------------------------------
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      numChecks = numChecks + 1;
      if (got !== exp)
      begin
         errTotal = errTotal + 1;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      numChecks = numChecks + 1;
      if (got !== exp)
      begin
         errTotal = errTotal + 1;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : check_resp

   task automatic write_ok(input logic [4:0] a, input logic [7:0] d);
      axi_write(a, d);
      check_resp(resp, bpaio_pkg::RESP_OKAY);
   endtask : write_ok

   task automatic read_expect(input logic [4:0] a, input logic [7:0] exp);
      axi_read(a);
      check_resp(resp, bpaio_pkg::RESP_OKAY);
      check_byte(rd[7:0], exp);
   endtask : read_expect

   task automatic finish_test();
      if (errTotal == 0 && numChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   //------------------------------------------
   // Main sequence
   //------------------------------------------
   initial
   begin
      rstn = 1'b0;
      req = '0;
      periph = '0;
      extLevel = 8'h00;
      wrStrb = 4'hF;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      check_byte(pinOe, 8'h00);
      read_expect(bpaio_pkg::OFS_PIN_DIR, 8'hFF);
      read_expect(bpaio_pkg::OFS_ANA_SEL, 8'h2F);
      read_expect(bpaio_pkg::OFS_OUT_LATCH, 8'h00);
      write_ok(bpaio_pkg::OFS_PIN_DIR, 8'h00);
      read_expect(bpaio_pkg::OFS_PIN_DIR, 8'h08);
      check_byte(pinOe, 8'hF7);
      write_ok(bpaio_pkg::OFS_ANA_SEL, 8'hFF);
      read_expect(bpaio_pkg::OFS_ANA_SEL, 8'h2F);
      write_ok(bpaio_pkg::OFS_ANA_SEL, 8'h00);
      write_ok(bpaio_pkg::OFS_OUT_LATCH, 8'hA5);
      check_byte(pinOut, 8'hA5);
      write_ok(bpaio_pkg::OFS_PIN_LEVEL, 8'h5A);
      read_expect(bpaio_pkg::OFS_OUT_LATCH, 8'h5A);
      // Pin three is an input, so it shows the board level
      repeat (3) @(posedge clock);
      read_expect(bpaio_pkg::OFS_PIN_LEVEL, 8'h52);
      write_ok(bpaio_pkg::OFS_PIN_DIR, 8'hFF);
      extLevel <= 8'hC3;
      repeat (3) @(posedge clock);
      read_expect(bpaio_pkg::OFS_PIN_LEVEL, 8'hC3);
      read_expect(bpaio_pkg::OFS_OUT_LATCH, 8'h5A);
      check_byte(digitalIn, 8'hC3);
      write_ok(bpaio_pkg::OFS_ANA_SEL, 8'h2F);
      repeat (3) @(posedge clock);
      read_expect(bpaio_pkg::OFS_PIN_LEVEL, 8'hC0);
      check_byte(digitalIn, 8'hC0);
      // Driven analog pin reads zero and loses its latch bit
      write_ok(bpaio_pkg::OFS_PIN_DIR, 8'h00);
      write_ok(bpaio_pkg::OFS_ANA_SEL, 8'h01);
      write_ok(bpaio_pkg::OFS_OUT_LATCH, 8'h01);
      check_byte(pinOe, 8'hF7);
      check_byte(pinOut, 8'h01);
      repeat (3) @(posedge clock);
      write_ok(bpaio_pkg::OFS_PIN_SET, 8'h80);
      read_expect(bpaio_pkg::OFS_OUT_LATCH, 8'h80);
      write_ok(bpaio_pkg::OFS_ANA_SEL, 8'h00);
      write_ok(bpaio_pkg::OFS_OUT_LATCH, 8'h0F);
      repeat (3) @(posedge clock);
      write_ok(bpaio_pkg::OFS_PIN_CLR, 8'h01);
      read_expect(bpaio_pkg::OFS_OUT_LATCH, 8'h06);
      // Modify registers read back as zero
      read_expect(bpaio_pkg::OFS_PIN_SET, 8'h00);
      read_expect(bpaio_pkg::OFS_PIN_CLR, 8'h00);
      // Low lane disabled: answered, but the latch keeps its value
      wrStrb = 4'h0;
      write_ok(bpaio_pkg::OFS_OUT_LATCH, 8'hFF);
      wrStrb = 4'hF;
      read_expect(bpaio_pkg::OFS_OUT_LATCH, 8'h06);
      // Peripherals override the latch, high level first
      periph <= '{hiEn: 8'h02, hiData: 8'h00, loEn: 8'h06, loData: 8'h02};
      repeat (2) @(posedge clock);
      check_byte(pinOut, 8'h00);
      axi_write(5'h18, 8'hFF);
      check_resp(resp, bpaio_pkg::RESP_SLVERR);
      axi_read(5'h18);
      check_resp(resp, bpaio_pkg::RESP_SLVERR);
      check_byte(rd[7:0], 8'h00);
      // Second reset restores analog mode
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      read_expect(bpaio_pkg::OFS_ANA_SEL, 8'h2F);
      finish_test();
   end
endmodule : bpaio_port_tb
